// [shared/tfs_consts.vh]
`ifndef TFS_CONSTS_VH
`define TFS_CONSTS_VH

// ********************************************************************
// register indices (byte address is four times the index)
// ********************************************************************
`define TFS_IDX_MASTER_CONFIG_TWO 8'h04
`define TFS_IDX_STATUS            8'h05
`define TFS_ADDR_MASTER_CONFIG_TWO 12'h010
`define TFS_ADDR_STATUS            12'h014

// ********************************************************************
// master_config_two fields
// ********************************************************************
`define TFS_MC2_CLK_INV      0
`define TFS_MC2_DATA_INV     1
`define TFS_MC2_DEMAND_INV   2
`define TFS_MC2_SYNC_INV     3
`define TFS_MC2_SYNC_OUT     4
`define TFS_MC2_MULTIFRAME   5
`define TFS_MC2_GAPPED       6
`define TFS_MC2_FREE_RUN     7
`define TFS_MC2_ERR_EN       8
`define TFS_MC2_LAST_TS_LO   9
`define TFS_MC2_LAST_TS_HI   10
`define TFS_MC2_WIDTH        11
`define TFS_MC2_RESET        11'h600

// ********************************************************************
// status fields
// ********************************************************************
`define TFS_ST_POS_HI        9
`define TFS_ST_FRAME_LO      10
`define TFS_ST_FRAME_HI      11
`define TFS_ST_ALIGNED       12
`define TFS_ST_ERRCNT_LO     16

// ********************************************************************
// frame timing
// ********************************************************************
`define TFS_FRAME_BITS       789
`define TFS_FRAMES_PER_MULTI 4
`define TFS_MULTI_BITS       3156
`define TFS_TS_BITS          8
`define TFS_TS_24            24
`define TFS_TS_48            48
`define TFS_TS_72            72
`define TFS_TS_96            96

`endif

// [rtl/tfs_sync.v]
`default_nettype none

// ********************************************************************
// two stage level synchroniser
// ********************************************************************
module tfs_sync #(
   parameter WIDTH = 1
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta     <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

// [rtl/tfs_system_port.v]
// How it works
// - sync pin is input after reset; falling edge sets framing bit one.
// - frame counter free-wheels; no sync pulse needed each frame.
// - sync output in frame mode pulses one clock every 789 clocks.
// - sync output in multiframe mode pulses one clock every 3156 clocks.
// - sync polarity selectable: active high normal, active low inverted.
// - 6.312 MHz clock supplied; payload taken on rising or falling edge.
// - payload sampled on selected edge and optionally inverted internally.
// - data-enable demand is active exactly over payload bit periods.
// - gapped demand toggles per payload bit, quiet during overhead bits.
// - free-run demand ignores sync alignment entirely.
// - demand output has its own inversion option in any mode.
// - when enabled, rising edge of error strobe starts error insertion.
// - last payload timeslot limited to 24, 48, 72 or 96.
// - clock edge, data and demand polarity live in master_config_two.
//
// The register offsets and register access over APB were decided locally.
`default_nettype none
`include "tfs_consts.vh"

module tfs_system_port #(
   parameter FRAME_BITS = `TFS_FRAME_BITS,
   parameter POS_W      = 10,
   parameter ERRCNT_W   = 8
) (
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   // system pins
   input  wire        tx_formatter_clock,
   input  wire        tx_frame_sync_in,
   output reg         tx_frame_sync_out,
   output wire        tx_frame_sync_oe,
   input  wire        tx_payload_in,
   output reg         tx_payload_demand,
   input  wire        tx_error_insert_strobe,
   // toward formatter core
   output reg         payload_bit,
   output reg         payload_valid,
   output reg         error_insert_start
);

   // ********************************************************************
   // register file
   // ********************************************************************
   reg  [`TFS_MC2_WIDTH-1:0] master_config_two;
   reg  [ERRCNT_W-1:0]       err_count;
   reg                       aligned;

   wire apb_setup = psel & ~penable;
   wire apb_write = psel & penable & pwrite;
   wire hit_mc2   = (paddr == `TFS_ADDR_MASTER_CONFIG_TWO);
   wire hit_st    = (paddr == `TFS_ADDR_STATUS);

   // slave never stalls
   assign pready = 1'b1;

   wire clk_inv    = master_config_two[`TFS_MC2_CLK_INV];
   wire data_inv   = master_config_two[`TFS_MC2_DATA_INV];
   wire demand_inv = master_config_two[`TFS_MC2_DEMAND_INV];
   wire sync_inv   = master_config_two[`TFS_MC2_SYNC_INV];
   wire sync_out   = master_config_two[`TFS_MC2_SYNC_OUT];
   wire multi_mode = master_config_two[`TFS_MC2_MULTIFRAME];
   wire gapped     = master_config_two[`TFS_MC2_GAPPED];
   wire free_run_demand_select = master_config_two[`TFS_MC2_FREE_RUN];
   wire err_en     = master_config_two[`TFS_MC2_ERR_EN];
   wire [1:0] last_ts_sel =
      master_config_two[`TFS_MC2_LAST_TS_HI:`TFS_MC2_LAST_TS_LO];

   // write on access phase; reserved bits are dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_config_two <= `TFS_MC2_RESET;
      end else if (apb_write && hit_mc2) begin
         master_config_two <= pwdata[`TFS_MC2_WIDTH-1:0];
      end
   end

   // ********************************************************************
   // tx clock edge detection and frame counters
   // ********************************************************************
   reg              tclk_q;
   reg              sync_prev;
   reg  [POS_W-1:0] pos;
   reg  [1:0]       frame_idx;
   reg  [POS_W-1:0] free_pos;

   wire clk_rise = tx_formatter_clock & ~tclk_q;
   wire clk_fall = ~tx_formatter_clock & tclk_q;
   wire bit_edge = clk_inv ? clk_fall : clk_rise;

   // pin is compared after polarity correction
   wire sync_norm = tx_frame_sync_in ^ sync_inv;
   wire sync_hit  = ~sync_out & sync_prev & ~sync_norm;

   localparam integer LAST_POS = FRAME_BITS - 1;
   wire [POS_W-1:0] last_pos = LAST_POS[POS_W-1:0];
   wire [POS_W-1:0] cur_pos  = sync_hit ? {POS_W{1'b0}} : pos;
   wire [POS_W-1:0] next_pos = (cur_pos == last_pos) ? {POS_W{1'b0}}
                               : cur_pos + 1'b1;
   wire [1:0] cur_frame  = sync_hit ? 2'b00 : frame_idx;
   wire [1:0] next_frame = (cur_pos == last_pos) ? cur_frame + 2'b01
                           : cur_frame;
   wire [POS_W-1:0] next_free = (free_pos == last_pos) ? {POS_W{1'b0}}
                                : free_pos + 1'b1;

   // sample the link clock level every cycle to find its edges
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tclk_q <= 1'b0;
      end else begin
         tclk_q <= tx_formatter_clock;
      end
   end

   // position counter free-wheels; a sync event only realigns it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_prev <= 1'b0;
         pos       <= {POS_W{1'b0}};
         frame_idx <= 2'b00;
         free_pos  <= {POS_W{1'b0}};
         aligned   <= 1'b0;
      end else if (bit_edge) begin
         sync_prev <= sync_norm;
         pos       <= next_pos;
         frame_idx <= next_frame;
         free_pos  <= next_free;
         if (sync_hit) begin
            aligned <= 1'b1;
         end
      end
   end

   // ********************************************************************
   // payload window
   // ********************************************************************
   reg [POS_W-1:0] payload_end;

   // window ends, cut to the counter width on purpose
   localparam integer END24 = `TFS_TS_24 * `TFS_TS_BITS;
   localparam integer END48 = `TFS_TS_48 * `TFS_TS_BITS;
   localparam integer END72 = `TFS_TS_72 * `TFS_TS_BITS;
   localparam integer END96 = `TFS_TS_96 * `TFS_TS_BITS;

   // last payload timeslot is one of four fixed choices
   always @* begin
      case (last_ts_sel)
         2'b00:   payload_end = END24[POS_W-1:0];
         2'b01:   payload_end = END48[POS_W-1:0];
         2'b10:   payload_end = END72[POS_W-1:0];
         default: payload_end = END96[POS_W-1:0];
      endcase
   end

   // position 0 is the framing bit; payload follows from position 1
   wire cur_payload  = (cur_pos != {POS_W{1'b0}}) &&
                       (cur_pos <= payload_end);
   wire next_payload = (pos != {POS_W{1'b0}}) && (pos <= payload_end);
   wire free_payload = (free_pos != {POS_W{1'b0}}) &&
                       (free_pos <= payload_end);

   // capture payload only on bits of the aligned payload window, even when free-run demand follows free_pos
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         payload_bit   <= 1'b0;
         payload_valid <= 1'b0;
      end else begin
         payload_valid <= bit_edge & cur_payload;
         if (bit_edge && cur_payload) begin
            payload_bit <= tx_payload_in ^ data_inv;
         end
      end
   end

   // ********************************************************************
   // demand output
   // ********************************************************************
   wire demand_win = free_run_demand_select ? free_payload
                     : next_payload;
   // gapped clock follows the link clock only inside the window
   wire demand_raw = gapped ? (demand_win & tclk_q)
                     : demand_win;

   // registered so the pin never glitches on counter changes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_payload_demand <= 1'b0;
      end else begin
         tx_payload_demand <= demand_raw ^ demand_inv;
      end
   end

   // ********************************************************************
   // frame sync output
   // ********************************************************************
   assign tx_frame_sync_oe = sync_out;

   // pulse spans the whole clock period of position 0
   wire frame_mark = (pos == {POS_W{1'b0}}) &&
                     (~multi_mode | (frame_idx == 2'b00));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_frame_sync_out <= 1'b0;
      end else begin
         tx_frame_sync_out <= (sync_out & frame_mark) ^ sync_inv;
      end
   end

   // ********************************************************************
   // error insert strobe
   // ********************************************************************
   wire err_sync;
   reg  err_prev;

   tfs_sync #(
      .WIDTH    (1)
   ) u_err_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (tx_error_insert_strobe),
      .sync_out (err_sync)
   );

   // a rise needs the strobe low again first, so one pulse per rise
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_prev           <= 1'b0;
         error_insert_start <= 1'b0;
         err_count          <= {ERRCNT_W{1'b0}};
      end else begin
         err_prev           <= err_sync;
         error_insert_start <= err_en & err_sync & ~err_prev;
         if (err_en && err_sync && !err_prev) begin
            err_count <= err_count + 1'b1;
         end
      end
   end

   // ********************************************************************
   // apb read path and error answer
   // ********************************************************************
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h0000_0000;
      if (hit_mc2) begin
         next_rdata[`TFS_MC2_WIDTH-1:0] = master_config_two;
      end else if (hit_st) begin
         next_rdata[`TFS_ST_POS_HI:0] = pos;
         next_rdata[`TFS_ST_FRAME_HI:`TFS_ST_FRAME_LO] = frame_idx;
         next_rdata[`TFS_ST_ALIGNED] = aligned;
         next_rdata[`TFS_ST_ERRCNT_LO+ERRCNT_W-1:`TFS_ST_ERRCNT_LO] =
            err_count;
      end
   end

   // data captured in setup so it stands through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         prdata  <= next_rdata;
         pslverr <= ~(hit_mc2 | (hit_st & ~pwrite));
      end
   end

endmodule

`default_nettype wire

// [verif/tfs_system_port_asserts.sv]
`default_nettype none
// ****************************************
// port checker
// ****************************************
module tfs_chk #(
   parameter int FRAME_BITS = 789
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        tx_formatter_clock,
   input wire logic        tx_frame_sync_out,
   input wire logic        tx_frame_sync_oe,
   input wire logic        tx_payload_in,
   input wire logic        tx_error_insert_strobe,
   input wire logic        payload_bit,
   input wire logic        payload_valid,
   input wire logic        error_insert_start
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [10:0] mc2;
   logic        tq;
   logic        seen;
   logic [12:0] cnt;
   wire logic   wr = psel & penable & pwrite & (paddr == 12'h010);
   wire logic   act = tx_frame_sync_out ^ mc2[3];
   wire logic   edg = mc2[0] ? (tq & ~tx_formatter_clock)
                              : (~tq & tx_formatter_clock);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // config shadow; bit edges counted from each sync start, so the
   // check does not depend on the design's edge-detect latency
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc2 <= 11'h600;
         tq <= 1'b0;
         seen <= 1'b0;
         cnt <= 13'h0;
      end else begin
         tq <= tx_formatter_clock;
         if (wr) mc2 <= pwdata[10:0];
         if (wr) seen <= 1'b0;
         // a polarity change right after a write is no real pulse
         else if ($rose(act) && tx_frame_sync_oe && !$past(wr)) seen <= 1'b1;
         if ($rose(act)) cnt <= {12'h0, edg};
         else if (edg) cnt <= cnt + 13'h1;
      end
   end
   a_sync_period:
   assert property ($rose(act) && tx_frame_sync_oe && seen
      |-> cnt == (mc2[5] ? 4 * FRAME_BITS : FRAME_BITS))
      else $error("sync period wrong");
   a_sync_width:
   assert property ($fell(act) && tx_frame_sync_oe && seen |-> cnt == 13'h1)
      else $error("sync pulse not one bit long");
   a_sync_dir:
   assert property (tx_frame_sync_oe == mc2[4])
      else $error("sync direction wrong");
   a_err_single:
   assert property (error_insert_start |=> !error_insert_start)
      else $error("error start longer than one cycle");
   a_err_cause:
   assert property (error_insert_start
      |-> $past(mc2[8]) && $past(tx_error_insert_strobe, 2))
      else $error("error start without enabled strobe");
   a_err_start:
   assert property ($rose(tx_error_insert_strobe) && mc2[8]
      |-> ##[2:5] error_insert_start)
      else $error("strobe rise not answered");
   a_valid_single:
   assert property (payload_valid |=> !payload_valid)
      else $error("payload valid too long");
   a_bit_value:
   assert property (payload_valid
      |-> payload_bit == $past(tx_payload_in ^ mc2[1]))
      else $error("payload bit wrong");
   a_bad_addr:
   assert property (psel && penable && paddr != 12'h010 && paddr != 12'h014
      |-> pslverr)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire

// [verif/tfs_user_logic.sv]
`default_nettype none
// ****************************************
// user framing logic model
// ****************************************
module tfs_user_logic #(
   parameter real HALF_NS = 79.2
) (
   input  wire logic capture_fall,
   output var  logic tx_clk,
   output var  logic data,
   output var  logic sync_drive
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] lfsr = 5'h1f;
   // free running reference, offset from pclk to keep clear of races
   initial begin
      tx_clk = 1'b0;
      data = 1'b0;
      sync_drive = 1'b1;
      #3;
      forever #(HALF_NS) tx_clk = ~tx_clk;
   end
   // data moves on the edge opposite capture, so it is settled when taken
   always @(tx_clk) begin
      if (tx_clk == capture_fall) begin
         lfsr <= {lfsr[3:0], lfsr[4] ^ lfsr[2]};
         data <= lfsr[0];
      end
   end
   // one falling sync event, then back to the pull-up level
   task send_sync;
      @(tx_clk iff (tx_clk == capture_fall));
      sync_drive = 1'b0;
      repeat (2) @(tx_clk iff (tx_clk == capture_fall));
      sync_drive = 1'b1;
   endtask
endmodule
`default_nettype wire

// [verif/tfs_system_port_test.sv]
`default_nettype none
`include "tfs_consts.vh"
// ****************************************
// bench
// ****************************************
module tfs_system_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BIT = 6; // pclk cycles per bit; shortened link clock
   localparam int FB = `TFS_FRAME_BITS;
   logic        pclk, presetn, psel, penable, pwrite, strobe, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, cfg;
   wire  [31:0] prdata;
   wire         pready, pslverr, txc, pin, sout, oe, din, dem;
   wire         drv, pbit, pvalid, estart;
   integer      mismatches, checks_done, ecount, cyc, vals, hi, rises;
   // released pin shows the model's pull-up level
   assign pin = oe ? sout : drv;
   tfs_system_port DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_formatter_clock(txc), .tx_frame_sync_in(pin),
      .tx_frame_sync_out(sout), .tx_frame_sync_oe(oe),
      .tx_payload_in(din), .tx_payload_demand(dem),
      .tx_error_insert_strobe(strobe), .payload_bit(pbit),
      .payload_valid(pvalid), .error_insert_start(estart));
   tfs_user_logic #(.HALF_NS(30.0)) u_user (.capture_fall(cfg[0]),
      .tx_clk(txc), .data(din), .sync_drive(drv));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) if (estart === 1'b1) ecount <= ecount + 1;
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task timeout;
      mismatches++;
      final_report;
   endtask
   task check(input logic [31:0] s, input logic [31:0] e, input string nm);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) timeout;
   endtask
   // align to one sync pulse, then count up to the next
   task frame;
      integer n;
      logic   a, pa, d, pd, r;
      n = 0;
      pa = 1'b1;
      pd = 1'b1;
      repeat (2) begin
         {cyc, vals, hi, rises} = 0;
         do begin
            @(posedge pclk);
            #1;
            a = sout ^ cfg[3];
            d = dem ^ cfg[2];
            r = a & !pa;
            pa = a;
            cyc++;
            n++;
            vals += pvalid;
            hi += d;
            rises += d & !pd;
            pd = d;
         end while (!r && n < 40000);
      end
      if (n >= 40000) timeout;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, strobe} = 5'h0;
      {paddr, pwdata} = 0;
      cfg = 32'h600;
      {mismatches, checks_done, ecount} = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `TFS_ADDR_MASTER_CONFIG_TWO, 0);
      check(rd, 32'h600, "reset cfg");
      apb(0, 12'h020, 0);
      check(er, 1'b1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      apb(1, `TFS_ADDR_STATUS, 32'hffffffff);
      check(er, 1'b1, "status write");
      u_user.send_sync;
      repeat (FB * BIT * 3 / 2) @(posedge pclk);
      apb(0, `TFS_ADDR_STATUS, 0);
      check(rd[`TFS_ST_ALIGNED], 1'b1, "aligned");
      check(rd[11:10], 2'h1, "frame index");
      // strobe ignored while disabled, then one start per rise
      for (int k = 0; k < 2; k++) begin
         cfg = 32'h600 | (k << 8);
         apb(1, `TFS_ADDR_MASTER_CONFIG_TWO, cfg);
         strobe <= 1'b1;
         repeat (10) @(posedge pclk);
         strobe <= 1'b0;
         repeat (10) @(posedge pclk);
         check(ecount, k, "starts");
      end
      apb(0, `TFS_ADDR_STATUS, 0);
      check(rd[23:16], 8'h1, "error count");
      // each last timeslot, both demand styles, clock, data and demand polarity
      for (int i = 0; i < 4; i++) begin
         cfg = 32'h10 | (i << 9) | ((i & 1) * 32'h42) | ((i >> 1) * 32'h5);
         if (i == 2) cfg = cfg | 32'h80;
         apb(1, `TFS_ADDR_MASTER_CONFIG_TWO, cfg);
         apb(0, `TFS_ADDR_MASTER_CONFIG_TWO, 0);
         check(rd, cfg, "cfg");
         frame;
         check(cyc, FB * BIT, "period");
         check(vals, (i + 1) * 192, "bits");
         hi = (i & 1) ? rises : hi / BIT;
         check(hi, (i + 1) * 192, "demand");
      end
      cfg = 32'h638;
      apb(1, `TFS_ADDR_MASTER_CONFIG_TWO, cfg);
      frame;
      check(cyc, 4 * FB * BIT, "multiframe");
      check(sout, 1'b0, "active low");
      final_report;
   end
endmodule
bind tfs_system_port tfs_chk #(.FRAME_BITS(FRAME_BITS)) u_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr),
   .tx_formatter_clock(tx_formatter_clock),
   .tx_frame_sync_out(tx_frame_sync_out), .tx_frame_sync_oe(tx_frame_sync_oe),
   .tx_payload_in(tx_payload_in),
   .tx_error_insert_strobe(tx_error_insert_strobe),
   .payload_bit(payload_bit), .payload_valid(payload_valid),
   .error_insert_start(error_insert_start));
`default_nettype wire
